// ==== timer8_regs.vh ====
// Register offsets, field positions and constants of the 8-bit timer block
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define T8_ADDR_CONTROL  12'h000
`define T8_ADDR_COUNT    12'h004
`define T8_ADDR_COMPARE  12'h008
`define T8_ADDR_FLAG     12'h00C
`define T8_ADDR_MASK     12'h010
`define T8_ADDR_STATUS   12'h014

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define T8_CS_LSB        0
`define T8_CS_MSB        2
`define T8_WGM0_BIT      3
`define T8_COM_LSB       4
`define T8_COM_MSB       5
`define T8_WGM1_BIT      6
`define T8_FOC_BIT       7

// Flag and mask bit positions
`define T8_OVF_BIT       0
`define T8_CMP_BIT       1

// Status register bit positions
`define T8_ST_OUT_BIT    0
`define T8_ST_DIR_BIT    1

// ------------------------------------------------------------
// Values
// ------------------------------------------------------------
`define T8_BOTTOM        8'h00
`define T8_MAX           8'hFF
`define T8_ZERO8         8'h00
`define T8_ZERO32        32'h0000_0000

// Waveform modes
`define T8_WGM_NORMAL    2'h0
`define T8_WGM_PCPWM     2'h1
`define T8_WGM_CTC       2'h2
`define T8_WGM_FAST      2'h3

// Output actions
`define T8_COM_NONE      2'h0
`define T8_COM_TOGGLE    2'h1
`define T8_COM_CLEAR     2'h2
`define T8_COM_SET       2'h3

// Tick sources
`define T8_CS_STOP       3'h0
`define T8_CS_DIV1       3'h1
`define T8_CS_DIV8       3'h2
`define T8_CS_DIV64      3'h3
`define T8_CS_DIV256     3'h4
`define T8_CS_DIV1024    3'h5
`define T8_CS_EXT_FALL   3'h6
`define T8_CS_EXT_RISE   3'h7

// Prescaler taps
`define T8_PRE_W         10
`define T8_TAP8          2
`define T8_TAP64         5
`define T8_TAP256        7
`define T8_TAP1024       9

`endif

// ==== timer8_count_compare_unit.v ====
// 8-bit timer/counter with one compare channel and an APB register slave
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "timer8_regs.vh"

// Behaviour
// - Count and compare are 8-bit readable/writable registers
// - Flags shared register, each gated by mask
// - Tick from prescaler or pin; zero stops
// - Bottom 0x00, max 0xFF, top mode-dependent
// - Each tick clears, increments or decrements
// - Count readable and writable at any time
// - Count write beats any counter update
// - Waveform mode sets sequence and overflow point
// - Overflow flag is a masked interrupt source
// - Comparator continuously checks count equals compare
// - Match sets compare flag next tick
// - Compare interrupt needs enable and global enable
// - Compare flag clears on service or one-write
// - Waveform generator drives output from match
// - Compare buffered in PWM, direct otherwise
// - Buffer copies to active at top (max) in both PWM modes
// - Software reaches buffer or active register
// - Force strobe makes match in non-PWM modes
// - Forced match updates output only
// - Count write blocks match next tick
// - Output state survives mode changes
// - Output action changes take effect immediately
// - Reset forces output state to zero
// - Normal mode counts up, wraps max to bottom
module timer8_count_compare_unit (
  input  wire        clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timer pins and system
  input  wire        extCountPin,
  input  wire        globalIrqEnable,
  input  wire        overflowIrqAck,
  input  wire        compareIrqAck,
  output reg         compareOutput,
  output reg         overflowIrq,
  output reg         compareIrq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg  [7:0]            countValue_q;     // Live counter
  reg  [7:0]            compareActive_q;  // Compared against counter
  reg  [7:0]            compareBuffer_q;  // PWM shadow of compare
  reg  [2:0]            tickSource_q;     // Tick source field
  reg  [1:0]            waveMode_q;       // Waveform mode field
  reg  [1:0]            outAction_q;      // Output action field
  reg                   overflowFlag_q;   // Sticky overflow
  reg                   compareFlag_q;    // Sticky compare
  reg                   overflowMask_q;   // Overflow enable
  reg                   compareMask_q;    // Compare irq enable
  reg                   countDown_q;      // Phase correct direction
  reg                   blockMatch_q;     // Match blocked after count write
  reg                   matchPend_q;      // Match waiting for next tick
  reg  [`T8_PRE_W-1:0]  prescale_q;       // Free running prescaler
  reg                   extSync1_q;       // Pin synchroniser first stage
  reg                   extSync2_q;       // Pin synchroniser second stage
  reg                   extPrev_q;        // Previous synced pin level
  // Software must set the output state, for example by a forced match,
  // before the pin is enabled, and must not write a count equal to the
  // compare value or write bottom while counting down: that match is lost.

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Zero wait state: answer on the first access cycle
  // Writes land at the access edge, when psel, penable and pwrite are
  // all high; the setup edge only prepares read data and the answer.
  // The slave never stalls, so a master that waits on pready is served
  // on its first access edge; unmapped words are refused with pslverr.
  wire apbWr = psel & penable & pwrite;
  wire apbRd = psel & penable & ~pwrite;
  wire wrCtl = apbWr & (paddr == `T8_ADDR_CONTROL);
  wire wrCnt = apbWr & (paddr == `T8_ADDR_COUNT);
  wire wrCmp = apbWr & (paddr == `T8_ADDR_COMPARE);
  wire wrFlg = apbWr & (paddr == `T8_ADDR_FLAG);
  wire wrMsk = apbWr & (paddr == `T8_ADDR_MASK);

  // Unmapped address check
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `T8_ADDR_CONTROL) | (a == `T8_ADDR_COUNT) |
               (a == `T8_ADDR_COMPARE) | (a == `T8_ADDR_FLAG) |
               (a == `T8_ADDR_MASK) | (a == `T8_ADDR_STATUS);
    end
  endfunction

  // PWM mode test, used by buffering and force logic
  function isPwm;
    input [1:0] m;
    begin
      isPwm = (m == `T8_WGM_PCPWM) | (m == `T8_WGM_FAST);
    end
  endfunction

  // Output action on a match
  function applyAction;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        `T8_COM_TOGGLE: applyAction = ~cur;
        `T8_COM_CLEAR:  applyAction = 1'b0;
        `T8_COM_SET:    applyAction = 1'b1;
        default:        applyAction = cur;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Tick selection
  // ------------------------------------------------------------
  wire [`T8_PRE_W-1:0] prescaleNext = prescale_q + {{(`T8_PRE_W-1){1'b0}}, 1'b1};
  // Tap rollover marks a divided tick
  // The prescaler runs freely and is never cleared by a control write,
  // so the first divided tick after a start may come early; this saves
  // a clear path and suits a prescaler shared by several timers.
  wire [`T8_PRE_W-1:0] rollBits = prescale_q & ~prescaleNext;
  reg                  timerTick;

  // Choose tick source; zero field stops the counter
  // Pin edges are seen three clocks after the pin moves; pulses shorter
  // than one clock may be lost, which limits the pin count rate.
  always @* begin
    case (tickSource_q)
      `T8_CS_DIV1:     timerTick = 1'b1;
      `T8_CS_DIV8:     timerTick = rollBits[`T8_TAP8];
      `T8_CS_DIV64:    timerTick = rollBits[`T8_TAP64];
      `T8_CS_DIV256:   timerTick = rollBits[`T8_TAP256];
      `T8_CS_DIV1024:  timerTick = rollBits[`T8_TAP1024];
      `T8_CS_EXT_FALL: timerTick = extPrev_q & ~extSync2_q;
      `T8_CS_EXT_RISE: timerTick = ~extPrev_q & extSync2_q;
      default:         timerTick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Counter, compare and waveform next state
  // ------------------------------------------------------------
  // The compare runs against the active register at every clock, but
  // only a tick turns a match into an effect, so a stopped counter
  // never sets the compare flag by itself.
  wire       atBottom = (countValue_q == `T8_BOTTOM);
  wire       atMax    = (countValue_q == `T8_MAX);
  wire       match    = (countValue_q == compareActive_q);
  wire       pwmMode  = isPwm(waveMode_q);
  wire       fcWrite  = wrCtl & pwdata[`T8_FOC_BIT];
  // Mode bits are not adjacent in the control word, so gather them here
  wire [1:0] ctlMode  = {pwdata[`T8_WGM1_BIT], pwdata[`T8_WGM0_BIT]};

  reg  [7:0] countD;
  reg        dirD;
  reg        ovfSet;
  reg        cmpSet;
  reg        outD;
  reg  [7:0] activeD;
  reg        matchEff;

  // Next count, direction, flags, output and active compare. Later
  // assignments override earlier ones, which is how a software write
  // beats the counter and how a forced match beats a real one.
  always @* begin
    countD   = countValue_q;
    dirD     = countDown_q;
    ovfSet   = 1'b0;
    cmpSet   = 1'b0;
    outD     = compareOutput;
    activeD  = compareActive_q;
    // A counted-in match acts on the following tick unless blocked
    matchEff = timerTick & matchPend_q & ~blockMatch_q;
    if (timerTick) begin
      case (waveMode_q)
        `T8_WGM_NORMAL: begin
          countD = countValue_q + 8'h01;
          ovfSet = atMax;
        end
        `T8_WGM_CTC: begin
          // Clear on match; a blocked match lets the count run past
          countD = (match & ~blockMatch_q) ? `T8_BOTTOM : countValue_q + 8'h01;
          ovfSet = atMax;
        end
        `T8_WGM_FAST: begin
          countD = countValue_q + 8'h01;
          ovfSet = atMax;
          if (atMax) begin
            activeD = compareBuffer_q;
          end
        end
        default: begin
          // Phase correct: up to max, down to bottom
          // Direction turns at max and at bottom; overflow marks bottom
          // Buffer reload at max keeps both slopes of a pulse equal
          if (countDown_q) begin
            if (atBottom) begin
              dirD   = 1'b0;
              countD = countValue_q + 8'h01;
              ovfSet = 1'b1;
            end else begin
              countD = countValue_q - 8'h01;
            end
          end else if (atMax) begin
            dirD    = 1'b1;
            countD  = countValue_q - 8'h01;
            activeD = compareBuffer_q;
          end else begin
            countD = countValue_q + 8'h01;
          end
        end
      endcase
      cmpSet = matchEff;
      // Waveform generation from match, and from max in fast PWM
      // In PWM modes action bit one enables the pin and bit zero inverts it
      case (waveMode_q)
        `T8_WGM_FAST: begin
          if (matchEff && outAction_q[1]) begin
            outD = outAction_q[0];
          end else if (atMax && outAction_q[1]) begin
            outD = ~outAction_q[0];
          end
        end
        `T8_WGM_PCPWM: begin
          if (matchEff && outAction_q[1]) begin
            outD = outAction_q[0] ^ countDown_q;
          end
        end
        default: begin
          if (matchEff) begin
            outD = applyAction(outAction_q, compareOutput);
          end
        end
      endcase
    end
    // Forced match: output only, no flag, no counter effect
    // The strobe uses the mode and action of its own control write
    if (fcWrite && !isPwm(ctlMode)) begin
      outD = applyAction(pwdata[`T8_COM_MSB:`T8_COM_LSB], compareOutput);
    end
    // Software write has priority over any counting
    if (wrCnt) begin
      countD = pwdata[7:0];
    end
    // Unbuffered modes write active compare directly
    // A PWM write reaches only the buffer, loaded at the next max
    if (wrCmp && !pwmMode) begin
      activeD = pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // All state reset to zero, counter stopped
  // Only constants in the reset branch, so release is clean
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countValue_q    <= `T8_ZERO8;
      compareActive_q <= `T8_ZERO8;
      compareBuffer_q <= `T8_ZERO8;
      tickSource_q    <= `T8_CS_STOP;
      waveMode_q      <= `T8_WGM_NORMAL;
      outAction_q     <= `T8_COM_NONE;
      overflowFlag_q  <= 1'b0;
      compareFlag_q   <= 1'b0;
      overflowMask_q  <= 1'b0;
      compareMask_q   <= 1'b0;
      countDown_q     <= 1'b0;
      blockMatch_q    <= 1'b0;
      matchPend_q     <= 1'b0;
      prescale_q      <= {`T8_PRE_W{1'b0}};
      extSync1_q      <= 1'b0;
      extSync2_q      <= 1'b0;
      extPrev_q       <= 1'b0;
      compareOutput   <= 1'b0;
      overflowIrq     <= 1'b0;
      compareIrq      <= 1'b0;
    end else begin
      prescale_q      <= prescaleNext;
      // Pin synchroniser, first stage read only by second
      // Third flop keeps the previous level for edge detection
      extSync1_q      <= extCountPin;
      extSync2_q      <= extSync1_q;
      extPrev_q       <= extSync2_q;
      countValue_q    <= countD;
      countDown_q     <= dirD;
      compareActive_q <= activeD;
      compareOutput   <= outD;
      // Match sampled on each tick, acted on at the next one
      // A match seen on the first tick after a count write is dropped,
      // so writing the compare value into the count raises no flag
      if (timerTick) begin
        matchPend_q <= match & ~blockMatch_q;
      end
      // Count write blocks the match of the following tick
      if (wrCnt) begin
        blockMatch_q <= 1'b1;
      end else if (timerTick) begin
        blockMatch_q <= 1'b0;
      end
      if (wrCmp) begin
        compareBuffer_q <= pwdata[7:0];
      end
      if (wrCtl) begin
        tickSource_q <= pwdata[`T8_CS_MSB:`T8_CS_LSB];
        waveMode_q   <= ctlMode;
        outAction_q  <= pwdata[`T8_COM_MSB:`T8_COM_LSB];
      end
      if (wrMsk) begin
        overflowMask_q <= pwdata[`T8_OVF_BIT];
        compareMask_q  <= pwdata[`T8_CMP_BIT];
      end
      // Set beats clear in the same cycle
      // Losing an event is worse than a spurious service, so a flag set by
      // hardware survives a write-one clear or a service in that cycle
      if (ovfSet) begin
        overflowFlag_q <= 1'b1;
      end else if ((wrFlg && pwdata[`T8_OVF_BIT]) || overflowIrqAck) begin
        overflowFlag_q <= 1'b0;
      end
      if (cmpSet) begin
        compareFlag_q <= 1'b1;
      end else if ((wrFlg && pwdata[`T8_CMP_BIT]) || compareIrqAck) begin
        compareFlag_q <= 1'b0;
      end
      // Interrupt requests, gated by mask and global enable
      // Including the set term saves a cycle of request latency
      overflowIrq <= (overflowFlag_q | ovfSet) & overflowMask_q & globalIrqEnable;
      compareIrq  <= (compareFlag_q | cmpSet) & compareMask_q & globalIrqEnable;
    end
  end

  // ------------------------------------------------------------
  // APB answer
  // ------------------------------------------------------------
  // Read data, ready and error registered in the access cycle
  // Read data is captured at the setup edge, so it shows the state one
  // cycle before the access edge; a write in that cycle is not seen.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= `T8_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata  <= `T8_ZERO32;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `T8_ADDR_CONTROL: prdata <= {24'h000000, 1'b0, waveMode_q[1], outAction_q,
                                       waveMode_q[0], tickSource_q};
          `T8_ADDR_COUNT:   prdata <= {24'h000000, countValue_q};
          `T8_ADDR_COMPARE: prdata <= {24'h000000,
                                       pwmMode ? compareBuffer_q : compareActive_q};
          `T8_ADDR_FLAG:    prdata <= {30'h0, compareFlag_q, overflowFlag_q};
          `T8_ADDR_MASK:    prdata <= {30'h0, compareMask_q, overflowMask_q};
          `T8_ADDR_STATUS:  prdata <= {30'h0, countDown_q, compareOutput};
          default:          prdata <= `T8_ZERO32;
        endcase
      end
    end
  end

endmodule // timer8_count_compare_unit

// ==== timer8_count_compare_unit_monitor.sv ====
// Port-level checker for the 8-bit timer register slave and outputs
`timescale 1ns/10ps
`include "timer8_regs.vh"

module timer8_count_compare_unit_monitor (
  input logic        clk,
  input logic        rstn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        globalIrqEnable,
  input logic        compareOutput,
  input logic        overflowIrq,
  input logic        compareIrq
);
  // ------------------------------------------------------------
  // One clock domain, reset disables everything
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Slave never stalls: answer in the cycle after setup
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  // Answer only inside an access that followed a setup
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  // Read data bus quiet unless a read is answered
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == `T8_ZERO32)
    else $error("prdata not zero while idle");
  // Unmapped word refused with an error
  a_unmapped_err: assert property (psel && !penable && paddr > `T8_ADDR_STATUS |=> pslverr)
    else $error("unmapped access without error");
  // Mapped aligned word never flagged
  a_mapped_ok: assert property (psel && !penable && paddr <= `T8_ADDR_STATUS
                                && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access flagged");
  // Requests need the global enable one cycle before
  a_ovf_gate: assert property (overflowIrq |-> $past(globalIrqEnable))
    else $error("overflow request without global enable");
  a_cmp_gate: assert property (compareIrq |-> $past(globalIrqEnable))
    else $error("compare request without global enable");
  // Output state starts low after every reset
  a_out_reset: assert property ($rose(rstn) |-> !compareOutput && !compareIrq)
    else $error("output not cleared by reset");
endmodule // timer8_count_compare_unit_monitor

bind timer8_count_compare_unit timer8_count_compare_unit_monitor u_mon (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .globalIrqEnable(globalIrqEnable), .compareOutput(compareOutput),
  .overflowIrq(overflowIrq), .compareIrq(compareIrq));

// ==== test_timer8_count_compare_unit.sv ====
// Self-checking bench for the 8-bit timer with compare channel
`timescale 1ns/10ps
`include "timer8_regs.vh"

module test_timer8_count_compare_unit;
  logic        clk, rstn, psel, penable, pwrite, extCountPin;
  logic        globalIrqEnable, overflowIrqAck, compareIrqAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, compareOutput, overflowIrq, compareIrq;
  logic [2:0]  pins;          // Output, compare request, overflow request
  int          err_count, total_checks, i, k;
  // ------------------------------------------------------------
  // Register rows: address, write data, read back, error
  // ------------------------------------------------------------
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  row_t rows [6] = '{
    '{`T8_ADDR_COUNT,   32'hFFFFFF5A, 32'h5A, 1'b0},
    '{`T8_ADDR_COMPARE, 32'h000000A5, 32'hA5, 1'b0},
    '{`T8_ADDR_MASK,    32'h00000003, 32'h03, 1'b0},
    '{`T8_ADDR_CONTROL, 32'h00000030, 32'h30, 1'b0},
    '{`T8_ADDR_CONTROL, 32'h00000000, 32'h00, 1'b0},
    '{12'h018,          32'h00000055, 32'h00, 1'b1}};

  timer8_count_compare_unit dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extCountPin(extCountPin), .globalIrqEnable(globalIrqEnable),
    .overflowIrqAck(overflowIrqAck), .compareIrqAck(compareIrqAck),
    .compareOutput(compareOutput), .overflowIrq(overflowIrq), .compareIrq(compareIrq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // One APB transfer plus an idle edge, so drivers never clash
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    // Access phase: request held until pready is seen at an edge
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        conclude();
      end
      @(posedge clk);
    end
    // Answer taken at the same edge that saw pready
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [11:0] a, input logic [31:0] x); apb(1'b0, a, 0); chk(rdat, x); endtask
  task cyc(input int n); repeat (n) @(posedge clk); endtask
  // Outputs sampled mid-cycle, where they have settled
  task look(input logic [2:0] x);
    @(negedge clk);
    pins = {compareOutput, compareIrq, overflowIrq};
    @(posedge clk);
    chk({29'h0, pins}, {29'h0, x});
  endtask
  // Bounded poll of one flag bit
  task waitbit(input int b);
    k = 0;
    rdat = 0;
    while (rdat[b] !== 1'b1) begin
      apb(1'b0, `T8_ADDR_FLAG, 0);
      k++;
      if (k > 400) begin err_count++; conclude(); end
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; extCountPin = 1'b0; globalIrqEnable = 1'b0;
    overflowIrqAck = 1'b0; compareIrqAck = 1'b0; err_count = 0; total_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++) rd(i[11:0] << 2, 0);
    look(3'b000);
    for (i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].x);
      chk({31'h0, rerr}, {31'h0, rows[i].e});
    end
    // Compare flag, request, service and overflow in normal mode
    wr(`T8_ADDR_FLAG, 3); wr(`T8_ADDR_COUNT, 0); wr(`T8_ADDR_COMPARE, 32'h10);
    wr(`T8_ADDR_CONTROL, 32'h01);
    waitbit(1);
    globalIrqEnable <= 1'b1;
    cyc(3);
    look(3'b010);
    compareIrqAck <= 1'b1;
    @(posedge clk);
    compareIrqAck <= 1'b0;
    cyc(2);
    look(3'b000);
    waitbit(0);
    look(3'b001);
    wr(`T8_ADDR_CONTROL, 0);
    globalIrqEnable <= 1'b0;
    cyc(2);
    look(3'b000);
    // Service of the overflow request clears its flag
    globalIrqEnable <= 1'b1;
    cyc(2);
    look(3'b001);
    overflowIrqAck <= 1'b1;
    @(posedge clk);
    overflowIrqAck <= 1'b0;
    cyc(2);
    look(3'b000);
    globalIrqEnable <= 1'b0;
    wr(`T8_ADDR_FLAG, 3);
    rd(`T8_ADDR_FLAG, 0);
    // Count write equal to compare hides the next match
    wr(`T8_ADDR_COMPARE, 32'h20); wr(`T8_ADDR_COUNT, 32'h20);
    wr(`T8_ADDR_CONTROL, 32'h01);
    cyc(100);
    wr(`T8_ADDR_CONTROL, 0);
    rd(`T8_ADDR_FLAG, 0);
    // Clear-on-match mode keeps the count at or below compare
    wr(`T8_ADDR_COUNT, 0); wr(`T8_ADDR_COMPARE, 5); wr(`T8_ADDR_CONTROL, 32'h41);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, `T8_ADDR_COUNT, 0);
      chk({31'h0, rdat <= 32'h5}, 1);
    end
    wr(`T8_ADDR_CONTROL, 0); wr(`T8_ADDR_FLAG, 3); wr(`T8_ADDR_COUNT, 32'h42);
    // Forced matches: toggle, clear, ignored in PWM, set, mode change
    wr(`T8_ADDR_CONTROL, 32'h90);
    look(3'b100);
    rd(`T8_ADDR_FLAG, 0);
    wr(`T8_ADDR_CONTROL, 32'hA0);
    look(3'b000);
    wr(`T8_ADDR_CONTROL, 32'hD8);
    look(3'b000);
    wr(`T8_ADDR_CONTROL, 32'hB0);
    wr(`T8_ADDR_CONTROL, 32'h48);
    look(3'b100);
    rd(`T8_ADDR_STATUS, 1);
    rd(`T8_ADDR_COUNT, 32'h42);
    // External pin rising edges as the tick source
    wr(`T8_ADDR_CONTROL, 0); wr(`T8_ADDR_COUNT, 0); wr(`T8_ADDR_CONTROL, 32'h07);
    for (i = 0; i < 10; i++) begin
      extCountPin <= 1'b1;
      cyc(4);
      extCountPin <= 1'b0;
      cyc(4);
    end
    cyc(6);
    wr(`T8_ADDR_CONTROL, 0);
    rd(`T8_ADDR_COUNT, 32'h0A);
    // Divide-by-eight tick: eighty edges hold exactly ten taps
    wr(`T8_ADDR_COUNT, 0);
    wr(`T8_ADDR_CONTROL, 32'h02);
    cyc(77);
    wr(`T8_ADDR_CONTROL, 0);
    rd(`T8_ADDR_COUNT, 32'h0A);
    // Phase correct: compare buffered, copied at max, then counting down
    wr(`T8_ADDR_CONTROL, 32'h08);
    wr(`T8_ADDR_COMPARE, 32'h77);
    rd(`T8_ADDR_COMPARE, 32'h77);
    wr(`T8_ADDR_CONTROL, 0);
    rd(`T8_ADDR_COMPARE, 32'h05);
    wr(`T8_ADDR_COUNT, 32'hF0);
    wr(`T8_ADDR_CONTROL, 32'h09);
    cyc(20);
    wr(`T8_ADDR_CONTROL, 0);
    rd(`T8_ADDR_COMPARE, 32'h77);
    rd(`T8_ADDR_COUNT, 32'hF7);
    rd(`T8_ADDR_STATUS, 3);
    // Second reset in mid-run clears output, direction and compare
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    @(posedge clk);
    look(3'b000);
    rd(`T8_ADDR_STATUS, 0);
    rd(`T8_ADDR_COMPARE, 0);
    conclude();
  end
endmodule // test_timer8_count_compare_unit
